// *** src/link_bist_ser.sv ***
// Serializer end of the link self test, with CRC counters and software port.
`timescale 1ns/1ps
// Behaviour
// (R1) Serializer enters test on back-channel enable.
// (R2) Test replaces video input with zero payload.
// (R3) Test payload goes through scramble and balance.
// (R4) Software toggles control bit 5 after enable.
// (R5) Test clock is TMDS or internal oscillator.
// (R6) Deserializer raises result high after lock.
// (R7) Result pulses low per errored frame.
// (R8) Result holds pass or fail after test.
// (R9) Enable pin duration sets test length.
// (R10) Lock stays valid throughout the test.
// (R11) Deserializer compares payload, records errors.
// (R12) CRC checked only after back-channel lock.
// (R13) Test CRC counter cleared on test entry.
// (R14) Functional CRC counter records from test entry.
// (R15) Test counter counts in test, retains result.
// (R16) Error counters saturate at maximum.
// ============================================================
// Software port map; each address holds one byte.
// The control byte is read/write; software pulses bit 5 once during the test sequence.
// The link status byte shows back-channel lock in bit 0.
// The functional and test CRC error counts are read only and saturate at their maximum.
// Interrupt status holds sticky bits: bit 0 test entry, bit 1 test exit, bit 2 CRC error.
// The interrupt enable byte has the same layout as the status byte.
// Writing ones to the interrupt clear byte clears those status bits; it reads as zero.
// Any write to the counter clear byte zeroes the counters unless a CRC error counts that cycle, the test count only outside test.
// Unmapped addresses read as zero and ignore writes.

module link_bist_ser
    import link_bist_pkg::*;
(
    input wire logic i_clock,
    input wire logic i_srst,
    link_bist_if.serializer link,
    input wire logic [PAYLOAD_BITS-1:0] i_video,
    input wire logic i_video_valid,
    input wire logic [7:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [7:0] o_rdata,
    output logic o_test_mode,
    output logic o_clk_osc,
    output logic o_irq
);
    // ============================================================
    // State registers.
    // Every bit of state here is set by the synchronous reset; all clear except the scrambler, which loads SCRAMBLE_SEED.
    logic test_r;
    logic clk_sel_r;
    logic [7:0] control_r;
    logic [7:0] func_crc_r;
    logic [7:0] test_crc_r;
    logic [IRQ_WIDTH-1:0] irq_stat_r;
    logic [IRQ_WIDTH-1:0] irq_en_r;
    logic [15:0] lfsr_r;
    logic balance_r;
    logic [PAYLOAD_BITS-1:0] fwd_data_r;
    logic fwd_valid_r;
    logic [7:0] rdata_r;
    logic irq_r;

    // ============================================================
    // Decoding and event terms.
    // Entry and exit look at the registered state, so each fires for one cycle only.
    wire enter_test = link.bc_valid && link.bc_test_enable && !test_r; // [R1]
    wire exit_test = link.bc_valid && !link.bc_test_enable && test_r; // [R9]
    wire crc_error = link.bc_valid && link.bc_lock && !link.bc_crc_ok; // [R12]
    wire wr_irq_en = i_wr && (i_addr == ADDR_IRQ_ENABLE);
    wire wr_irq_clr = i_wr && (i_addr == ADDR_IRQ_CLEAR);
    wire wr_crc_clr = i_wr && (i_addr == ADDR_CRC_CLEAR);
    wire wr_control = i_wr && (i_addr == ADDR_CONTROL);
    wire [IRQ_WIDTH-1:0] irq_events = {crc_error, exit_test, enter_test};

    // Test counter counts only in test and is cleared by software only outside it.
    wire test_crc_inc = crc_error && test_r; // [R15]
    wire test_crc_clr = wr_crc_clr && !test_r; // [R15]
    // Interrupt clear mask is zero unless the clear byte is written this cycle.
    wire [IRQ_WIDTH-1:0] irq_clr_mask = wr_irq_clr ? i_wdata[IRQ_WIDTH-1:0] : {IRQ_WIDTH{1'b0}};
    wire irq_pending = |(irq_stat_r & irq_en_r);

    // Test payload is all zeroes; the same scrambler and balance stage serve both.
    // The keystream spreads the 16-bit scrambler state over the whole payload width.
    wire [PAYLOAD_BITS-1:0] payload = test_r ? {PAYLOAD_BITS{1'b0}} : i_video; // [R2]
    wire [PAYLOAD_BITS-1:0] keystream = {lfsr_r[3:0], lfsr_r, lfsr_r};
    wire [PAYLOAD_BITS-1:0] scrambled = payload ^ keystream; // [R3]
    wire [PAYLOAD_BITS-1:0] balanced = balance_r ? ~scrambled : scrambled; // [R3]
    wire send = test_r || i_video_valid; // [R2]

    // Read multiplexer; unmapped and write-only addresses read zero.
    // The link status byte reads the live lock bit, one back-channel frame behind the far end.
    wire [7:0] rd_mux =
        (i_addr == ADDR_CONTROL) ? control_r :
        (i_addr == ADDR_LINK_STATUS) ? {7'h00, link.bc_lock} : // [R12]
        (i_addr == ADDR_FUNC_CRC) ? func_crc_r :
        (i_addr == ADDR_TEST_CRC) ? test_crc_r :
        (i_addr == ADDR_IRQ_STATUS) ? {5'h00, irq_stat_r} :
        (i_addr == ADDR_IRQ_ENABLE) ? {5'h00, irq_en_r} : RESET_BYTE;

    // ============================================================
    // Test mode and clock source follow the back-channel indication.
    // Only frames marked valid are acted on, so an idle back channel leaves the mode as it is.
    // The clock select is tracked outside test too, so o_clk_osc shows it before a run.
    always_ff @(posedge i_clock) begin
        if (i_srst) begin
            test_r <= 1'b0;
            clk_sel_r <= CLK_TMDS;
        end else begin
            if (enter_test) begin
                test_r <= 1'b1; // [R1]
            end else if (exit_test) begin
                test_r <= 1'b0; // [R9]
            end
            if (link.bc_valid) begin
                clk_sel_r <= link.bc_clk_sel; // [R5]
            end
        end
    end

    // Control byte is plain storage; software pulses bit 5 during the sequence.
    // Bit 5 has no effect of its own here; it is kept so software can read its toggles back.
    always_ff @(posedge i_clock) begin
        if (i_srst) begin
            control_r <= RESET_BYTE;
        end else if (wr_control) begin
            control_r <= i_wdata; // [R4]
        end
    end

    // Functional counter restarts at entry and keeps counting; test counter counts in test only.
    // The entry clear has priority: a CRC error in the entry cycle belongs to no run.
    // An increment beats a software clear in the same cycle, so no error is lost.
    always_ff @(posedge i_clock) begin
        if (i_srst) begin
            func_crc_r <= RESET_BYTE;
            test_crc_r <= RESET_BYTE;
        end else if (enter_test) begin
            func_crc_r <= RESET_BYTE; // [R13] [R14]
            test_crc_r <= RESET_BYTE; // [R13]
        end else begin
            if (crc_error) begin
                func_crc_r <= sat_inc(func_crc_r); // [R14] [R16]
            end else if (wr_crc_clr) begin
                func_crc_r <= RESET_BYTE;
            end
            if (test_crc_inc) begin
                test_crc_r <= sat_inc(test_crc_r); // [R15] [R16]
            end else if (test_crc_clr) begin
                test_crc_r <= RESET_BYTE; // [R15]
            end
        end
    end

    // Sticky interrupt bits; a new event wins over a clear in the same cycle.
    // The interrupt output lags the status by one cycle because it comes from a flip-flop.
    always_ff @(posedge i_clock) begin
        if (i_srst) begin
            irq_stat_r <= '0;
            irq_en_r <= '0;
            irq_r <= 1'b0;
        end else begin
            irq_stat_r <= irq_events | (irq_stat_r & ~irq_clr_mask);
            if (wr_irq_en) begin
                irq_en_r <= i_wdata[IRQ_WIDTH-1:0];
            end
            irq_r <= irq_pending;
        end
    end

    // Forward frame path: scrambler advances per frame, balance flips per frame.
    // There is no alignment word: both ends leave reset together with the same seed.
    // Limitation: a single lost frame valid would put the two scramblers out of step for good.
    always_ff @(posedge i_clock) begin
        if (i_srst) begin
            lfsr_r <= SCRAMBLE_SEED;
            balance_r <= 1'b0;
            fwd_data_r <= '0;
            fwd_valid_r <= 1'b0;
        end else begin
            fwd_valid_r <= send;
            if (send) begin
                fwd_data_r <= balanced;
                lfsr_r <= lfsr_step(lfsr_r);
                balance_r <= ~balance_r;
            end
        end
    end

    // Read data stand one cycle after the strobe only.
    // Reads have no side effects, so software may poll status freely.
    always_ff @(posedge i_clock) begin
        if (i_srst) begin
            rdata_r <= RESET_BYTE;
        end else begin
            rdata_r <= i_rd ? rd_mux : RESET_BYTE;
        end
    end

    // ============================================================
    // Outputs come straight from registers, so the pins never show decode glitches.
    assign link.fwd_data = fwd_data_r;
    assign link.fwd_valid = fwd_valid_r;
    assign o_rdata = rdata_r;
    assign o_test_mode = test_r;
    assign o_clk_osc = clk_sel_r;
    assign o_irq = irq_r;
endmodule

// *** src/link_bist_pkg.sv ***
// Shared constants and types for the serial link self-test ends.
package link_bist_pkg;
    // ============================================================
    // Register map of the serializer-side software port.
    localparam logic [7:0] ADDR_CONTROL = 8'h04;
    localparam logic [7:0] ADDR_LINK_STATUS = 8'h0C;
    localparam logic [7:0] ADDR_FUNC_CRC = 8'h10;
    localparam logic [7:0] ADDR_TEST_CRC = 8'h11;
    localparam logic [7:0] ADDR_IRQ_STATUS = 8'h12;
    localparam logic [7:0] ADDR_IRQ_ENABLE = 8'h13;
    localparam logic [7:0] ADDR_IRQ_CLEAR = 8'h14;
    localparam logic [7:0] ADDR_CRC_CLEAR = 8'h15;
    // Deserializer-side software port.
    localparam logic [7:0] ADDR_DES_CONTROL = 8'h00;
    localparam logic [7:0] ADDR_DES_STATUS = 8'h01;
    localparam logic [7:0] ADDR_DES_ERRORS = 8'h02;
    // ============================================================
    // Field positions.
    localparam int CTRL_TOGGLE_BIT = 5;
    localparam int LINK_DETECT_BIT = 0;
    localparam int DCTRL_ENABLE_BIT = 0;
    localparam int DCTRL_CLKSEL_BIT = 1;
    localparam int IRQ_ENTER_BIT = 0;
    localparam int IRQ_EXIT_BIT = 1;
    localparam int IRQ_CRC_BIT = 2;
    localparam int IRQ_WIDTH = 3;
    // ============================================================
    // Reset values and figures.
    localparam logic [7:0] RESET_BYTE = 8'h00;
    localparam logic [7:0] COUNT_MAX = 8'hFF;
    localparam int PAYLOAD_BITS = 36;
    localparam int CHECK_LOW = 1;
    localparam int CHECK_HIGH = 35;
    localparam logic [15:0] SCRAMBLE_SEED = 16'hACE1;
    // Test clock source select.
    typedef enum logic {CLK_TMDS = 1'b0, CLK_OSC = 1'b1} clk_src_e;
    // Deserializer check state.
    typedef enum logic [1:0] {
        DS_IDLE = 2'b00,
        DS_WAIT_LOCK = 2'b01,
        DS_CHECK = 2'b10,
        DS_HOLD = 2'b11
    } des_state_e;

    // Saturating 8-bit increment shared by every error counter.
    function automatic logic [7:0] sat_inc(input logic [7:0] v);
        sat_inc = (v == COUNT_MAX) ? COUNT_MAX : v + 8'h01;
    endfunction

    // One step of the 16-bit scrambler sequence.
    function automatic logic [15:0] lfsr_step(input logic [15:0] s);
        lfsr_step = {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction
endpackage

// *** src/link_bist_if.sv ***
// Link between serializer and deserializer: forward frames and back channel.
`timescale 1ns/1ps
interface link_bist_if;
    import link_bist_pkg::*;
    logic [PAYLOAD_BITS-1:0] fwd_data;
    logic fwd_valid;
    logic bc_valid;
    logic bc_test_enable;
    logic bc_clk_sel;
    logic bc_crc_ok;
    logic bc_lock;

    modport serializer (
        output fwd_data, fwd_valid,
        input bc_valid, bc_test_enable, bc_clk_sel, bc_crc_ok, bc_lock
    );
    modport deserializer (
        input fwd_data, fwd_valid,
        output bc_valid, bc_test_enable, bc_clk_sel, bc_crc_ok, bc_lock
    );
endinterface

// *** src/link_bist_des.sv ***
// Deserializer end of the link self test: enable, checking and result pin.
`timescale 1ns/1ps
module link_bist_des
    import link_bist_pkg::*;
(
    input wire logic i_clock,
    input wire logic i_srst,
    link_bist_if.deserializer link,
    input wire logic i_selftest_enable_pin,
    input wire logic i_selftest_clock_select_pin,
    input wire logic i_lock,
    input wire logic i_bc_crc_ok,
    input wire logic [7:0] i_addr,
    input wire logic [7:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [7:0] o_rdata,
    output logic o_pass,
    output logic o_lock
);
    // ============================================================
    des_state_e state_r;
    des_state_e state_nxt;
    logic [1:0] dctrl_r;
    logic [7:0] err_r;
    logic failed_r;
    logic pass_r;
    logic [15:0] lfsr_r;
    logic balance_r;
    logic [7:0] rdata_r;
    logic bc_valid_r;
    logic bc_en_r;
    logic bc_clk_r;
    logic bc_crc_r;
    logic bc_lock_r;

    // Enable by pin or register; clock select likewise.
    wire test_on = i_selftest_enable_pin || dctrl_r[DCTRL_ENABLE_BIT]; // [R1] [R9]
    wire clk_sel = i_selftest_clock_select_pin || dctrl_r[DCTRL_CLKSEL_BIT]; // [R5]
    wire checking = (state_r == DS_CHECK) && i_lock; // [R10]

    // Undo balance and scrambling, then look for any set bit in the checked span.
    wire [PAYLOAD_BITS-1:0] keystream = {lfsr_r[3:0], lfsr_r, lfsr_r};
    wire [PAYLOAD_BITS-1:0] unbal = balance_r ? ~link.fwd_data : link.fwd_data;
    wire [PAYLOAD_BITS-1:0] recovered = unbal ^ keystream;
    wire frame_err = checking && link.fwd_valid && (|recovered[CHECK_HIGH:CHECK_LOW]); // [R7] [R11]

    wire [7:0] rd_mux =
        (i_addr == ADDR_DES_CONTROL) ? {6'h00, dctrl_r} :
        (i_addr == ADDR_DES_STATUS) ? {5'h00, failed_r, i_lock, test_on} :
        (i_addr == ADDR_DES_ERRORS) ? err_r : RESET_BYTE;

    // ============================================================
    // Check sequencer.
    always_comb begin
        state_nxt = state_r;
        case (state_r)
            DS_IDLE, DS_HOLD: begin
                if (test_on) begin
                    state_nxt = DS_WAIT_LOCK;
                end
            end
            DS_WAIT_LOCK: begin
                if (!test_on) begin
                    state_nxt = DS_HOLD;
                end else if (i_lock) begin
                    state_nxt = DS_CHECK; // [R6]
                end
            end
            DS_CHECK: begin
                if (!test_on) begin
                    state_nxt = DS_HOLD; // [R9]
                end
            end
            default: state_nxt = DS_IDLE;
        endcase
    end

    always_ff @(posedge i_clock) begin
        if (i_srst) begin
            state_r <= DS_IDLE;
            dctrl_r <= 2'b00;
        end else begin
            state_r <= state_nxt;
            if (i_wr && (i_addr == ADDR_DES_CONTROL)) begin
                dctrl_r <= i_wdata[1:0];
            end
        end
    end

    // Error count and result pin; a low pulse lasts one cycle, a half pixel period here.
    always_ff @(posedge i_clock) begin
        if (i_srst) begin
            err_r <= RESET_BYTE;
            failed_r <= 1'b0;
            pass_r <= 1'b0;
        end else if (state_r != DS_WAIT_LOCK && state_nxt == DS_WAIT_LOCK) begin
            err_r <= RESET_BYTE;
            failed_r <= 1'b0;
            pass_r <= 1'b0;
        end else begin
            if (frame_err) begin
                err_r <= sat_inc(err_r); // [R11]
                failed_r <= 1'b1;
            end
            if (state_r == DS_CHECK) begin
                pass_r <= !frame_err; // [R6] [R7]
            end else if (state_r == DS_HOLD) begin
                pass_r <= !failed_r; // [R8]
            end
        end
    end

    // Descrambler follows the serializer per frame.
    always_ff @(posedge i_clock) begin
        if (i_srst) begin
            lfsr_r <= SCRAMBLE_SEED;
            balance_r <= 1'b0;
        end else if (link.fwd_valid) begin
            lfsr_r <= lfsr_step(lfsr_r);
            balance_r <= ~balance_r;
        end
    end

    // Back-channel frame each cycle, plus software read port.
    always_ff @(posedge i_clock) begin
        if (i_srst) begin
            bc_valid_r <= 1'b0;
            bc_en_r <= 1'b0;
            bc_clk_r <= CLK_TMDS;
            bc_crc_r <= 1'b1;
            bc_lock_r <= 1'b0;
            rdata_r <= RESET_BYTE;
        end else begin
            bc_valid_r <= 1'b1;
            bc_en_r <= test_on; // [R1]
            bc_clk_r <= clk_sel; // [R5]
            bc_crc_r <= i_bc_crc_ok;
            bc_lock_r <= i_lock;
            rdata_r <= i_rd ? rd_mux : RESET_BYTE;
        end
    end

    assign link.bc_valid = bc_valid_r;
    assign link.bc_test_enable = bc_en_r;
    assign link.bc_clk_sel = bc_clk_r;
    assign link.bc_crc_ok = bc_crc_r;
    assign link.bc_lock = bc_lock_r;
    assign o_rdata = rdata_r;
    assign o_pass = pass_r;
    assign o_lock = i_lock;
endmodule

// *** verif/link_bist_checker.sv ***
// Checker of the link signals between the two self-test ends.
`timescale 1ns/1ps
// ============================================================
// Assertions on forward frames and back channel.
module link_bist_checker
    import link_bist_pkg::*;
(
    input wire logic i_clock,
    input wire logic i_srst,
    input wire logic [PAYLOAD_BITS-1:0] fwd_data,
    input wire logic fwd_valid,
    input wire logic bc_valid,
    input wire logic bc_test_enable,
    input wire logic bc_clk_sel,
    input wire logic bc_crc_ok,
    input wire logic bc_lock
);
    default clocking cb @(posedge i_clock); endclocking
    default disable iff (i_srst);
    // Entry of test and a settled run of test cycles.
    sequence s_enter;
        $rose(bc_test_enable) && bc_valid;
    endsequence
    sequence s_run;
        bc_test_enable[*4];
    endsequence
    property p_reset_idle;
        $fell(i_srst) |-> !bc_test_enable && !fwd_valid && bc_crc_ok;
    endproperty
    a_reset_idle: assert property (p_reset_idle) else $error("link not idle after reset");
    property p_enter_frames;
        s_enter |-> ##2 fwd_valid[*2];
    endproperty
    a_enter_frames: assert property (p_enter_frames) else $error("no frames after entry");
    property p_zero_frames;
        s_run |-> fwd_valid;
    endproperty
    a_zero_frames: assert property (p_zero_frames) else $error("frame missing in test");
    property p_scrambled;
        s_run ##1 bc_test_enable |-> !$stable(fwd_data);
    endproperty
    a_scrambled: assert property (p_scrambled) else $error("test frames not scrambled");
    property p_nonzero;
        s_run |-> fwd_data != '0;
    endproperty
    a_nonzero: assert property (p_nonzero) else $error("raw zero frame on link");
    property p_clk_stable;
        bc_test_enable[*2] |-> $stable(bc_clk_sel);
    endproperty
    a_clk_stable: assert property (p_clk_stable) else $error("clock select moved in test");
    property p_lock_held;
        bc_test_enable && $past(bc_test_enable) && $past(bc_lock) |-> bc_lock;
    endproperty
    a_lock_held: assert property (p_lock_held) else $error("lock lost in test");
    property p_enable_held;
        s_enter |-> bc_test_enable[*3];
    endproperty
    a_enable_held: assert property (p_enable_held) else $error("enable too short");
endmodule

// *** verif/serial_link_bist_tb.sv ***
// Self-checking bench joining serializer and deserializer self-test ends.
`timescale 1ns/1ps
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin error_cnt++; \
    $display("Error at %0t: got %h expected %h", $time, a, b); end end
module serial_link_bist_tb
    import link_bist_pkg::*;
;
    logic clock, srst, wr_s, rd_s, wr_d, rd_d, vvalid, en_pin, clk_pin, lock, crc_ok;
    logic test_mode, clk_osc, irq, pass, lock_out;
    logic [7:0] addr, wdata, rdata_s, rdata_d;
    logic [PAYLOAD_BITS-1:0] video;
    int error_cnt, num_checks, cycles, n;
    link_bist_if lnk();
    link_bist_ser i_link_bist_ser (.i_clock(clock), .i_srst(srst), .link(lnk), .i_video(video),
        .i_video_valid(vvalid), .i_addr(addr), .i_wdata(wdata), .i_wr(wr_s), .i_rd(rd_s),
        .o_rdata(rdata_s), .o_test_mode(test_mode), .o_clk_osc(clk_osc), .o_irq(irq));
    link_bist_des i_link_bist_des (.i_clock(clock), .i_srst(srst), .link(lnk),
        .i_selftest_enable_pin(en_pin), .i_selftest_clock_select_pin(clk_pin), .i_lock(lock),
        .i_bc_crc_ok(crc_ok), .i_addr(addr), .i_wdata(wdata), .i_wr(wr_d), .i_rd(rd_d),
        .o_rdata(rdata_d), .o_pass(pass), .o_lock(lock_out));
    link_bist_checker i_link_bist_checker (.i_clock(clock), .i_srst(srst), .fwd_data(lnk.fwd_data),
        .fwd_valid(lnk.fwd_valid), .bc_valid(lnk.bc_valid), .bc_test_enable(lnk.bc_test_enable),
        .bc_clk_sel(lnk.bc_clk_sel), .bc_crc_ok(lnk.bc_crc_ok), .bc_lock(lnk.bc_lock));
    // ============================================================
    // Clock, video noise and hang guard.
    initial begin
        clock = 1'b0;
        forever #20 clock = ~clock;
    end
    // Video keeps changing so a test that still samples it shows up on the link.
    always @(posedge clock) begin
        video <= PAYLOAD_BITS'({$urandom(), $urandom()});
        vvalid <= 1'($urandom());
    end
    // Far more cycles than the sequence needs, so only a hang reaches it.
    always @(posedge clock) begin
        cycles++;
        if (cycles == 5000) begin
            error_cnt++;
            print_verdict();
        end
    end
    // ============================================================
    // Bus tasks and expectations.
    task automatic wr(input logic d, input logic [7:0] a, input logic [7:0] x);
        @(posedge clock);
        addr <= a;
        wdata <= x;
        wr_s <= !d;
        wr_d <= d;
        @(posedge clock);
        wr_s <= 1'b0;
        wr_d <= 1'b0;
    endtask
    // Read data stand only in the cycle after the strobe.
    task automatic rd_chk(input logic d, input logic [7:0] a, input logic [7:0] e);
        @(posedge clock);
        addr <= a;
        rd_s <= !d;
        rd_d <= d;
        @(posedge clock);
        rd_s <= 1'b0;
        rd_d <= 1'b0;
        #1 `CHK(d ? rdata_d : rdata_s, e)
    endtask
    // Each cycle of a bad back-channel CRC is one error.
    task automatic inject(input int k);
        repeat (k) begin
            @(posedge clock);
            crc_ok <= 1'b0;
        end
        @(posedge clock);
        crc_ok <= 1'b1;
        repeat (4) @(posedge clock);
    endtask
    function automatic logic [7:0] exp_cnt(input int k);
        return (k > 255) ? 8'hFF : k[7:0];
    endfunction
    task automatic print_verdict();
        if (error_cnt == 0 && num_checks > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    // ============================================================
    // Main sequence: pin-driven test, then register-driven test.
    initial begin
        void'($urandom(32'h5fd2_226a));
        {srst, wr_s, rd_s, wr_d, rd_d, en_pin, clk_pin, lock, crc_ok} = 9'h103;
        {addr, wdata, video, vvalid, error_cnt, num_checks, cycles} = '0;
        repeat (20) @(posedge clock);
        srst <= 1'b0;
        rd_chk(0, ADDR_TEST_CRC, 8'h00);
        rd_chk(0, 8'h3F, 8'h00);
        rd_chk(1, ADDR_DES_STATUS, 8'h02);
        wr(0, ADDR_IRQ_ENABLE, 8'h07);
        @(posedge clock);
        en_pin <= 1'b1;
        repeat (2) @(posedge clock);
        #1 `CHK(test_mode, 1'b1)
        `CHK(clk_osc, 1'b0)
        wr(0, ADDR_CONTROL, 8'h20);
        rd_chk(0, ADDR_CONTROL, 8'h20);
        wr(0, ADDR_CONTROL, 8'h00);
        rd_chk(0, ADDR_CONTROL, 8'h00);
        `CHK(irq, 1'b1)
        n = 1 + $urandom_range(40);
        inject(n);
        rd_chk(0, ADDR_FUNC_CRC, exp_cnt(n));
        rd_chk(0, ADDR_TEST_CRC, exp_cnt(n));
        rd_chk(0, ADDR_IRQ_STATUS, 8'h05);
        `CHK(pass, 1'b1)
        wr(0, ADDR_IRQ_CLEAR, 8'h07);
        wr(0, ADDR_IRQ_ENABLE, 8'h00);
        rd_chk(0, ADDR_IRQ_STATUS, 8'h00);
        `CHK(irq, 1'b0)
        @(posedge clock);
        en_pin <= 1'b0;
        repeat (4) @(posedge clock);
        #1 `CHK(test_mode, 1'b0)
        `CHK(pass, 1'b1)
        `CHK(irq, 1'b0)
        rd_chk(0, ADDR_IRQ_STATUS, 8'h02);
        rd_chk(1, ADDR_DES_STATUS, 8'h02);
        rd_chk(1, ADDR_DES_ERRORS, 8'h00);
        inject(3);
        rd_chk(0, ADDR_TEST_CRC, exp_cnt(n));
        // Second run starts without lock, so early errors must not count.
        @(posedge clock);
        lock <= 1'b0;
        wr(1, ADDR_DES_CONTROL, 8'h03);
        repeat (3) @(posedge clock);
        #1 `CHK(clk_osc, 1'b1)
        `CHK(test_mode, 1'b1)
        `CHK(pass, 1'b0)
        `CHK(lock_out, 1'b0)
        rd_chk(0, ADDR_LINK_STATUS, 8'h00);
        inject(5);
        rd_chk(0, ADDR_TEST_CRC, 8'h00);
        rd_chk(0, ADDR_FUNC_CRC, 8'h00);
        @(posedge clock);
        lock <= 1'b1;
        rd_chk(0, ADDR_LINK_STATUS, 8'h01);
        `CHK(lock_out, 1'b1)
        inject(300);
        rd_chk(0, ADDR_TEST_CRC, exp_cnt(300));
        rd_chk(0, ADDR_FUNC_CRC, exp_cnt(300));
        wr(1, ADDR_DES_CONTROL, 8'h00);
        repeat (4) @(posedge clock);
        #1 `CHK(pass, 1'b1)
        `CHK(clk_osc, 1'b0)
        // The clock select pin alone must reach the serializer as well.
        @(posedge clock);
        clk_pin <= 1'b1;
        repeat (3) @(posedge clock);
        #1 `CHK(clk_osc, 1'b1)
        wr(0, ADDR_CRC_CLEAR, 8'h01);
        rd_chk(0, ADDR_TEST_CRC, 8'h00);
        print_verdict();
    end
endmodule
